/* design/dss_params.svh */
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
// Timing
`define DSS_CLK_NS 20
`define DSS_TICK_NS 100000000
// Register byte offsets
`define DSS_A_CTRL 8'h00
`define DSS_A_START_MTH 8'h04
`define DSS_A_START_FREQ 8'h08
`define DSS_A_START_HOLD 8'h0c
`define DSS_A_START_CUR 8'h10
`define DSS_A_START_TIME 8'h14
`define DSS_A_RAMP_SHAPE 8'h18
`define DSS_A_S_HEAD 8'h1c
`define DSS_A_S_TAIL 8'h20
`define DSS_A_STOP_MTH 8'h24
`define DSS_A_STOP_FREQ 8'h28
`define DSS_A_STOP_DELAY 8'h2c
`define DSS_A_STOP_CUR 8'h30
`define DSS_A_STOP_HOLD 8'h34
`define DSS_A_TARGET 8'h38
`define DSS_A_ACC_STEP 8'h3c
`define DSS_A_DEC_STEP 8'h40
`define DSS_A_STATUS 8'h44
`define DSS_A_RUNTIME 8'h48
// Control field positions
`define DSS_CTRL_RUN 0
`define DSS_CTRL_DIR 1
`define DSS_CTRL_ASYNC 2
// Limits and reset values
`define DSS_FREQ_MAX 16'h03e8
`define DSS_HOLD_MAX 16'h03e8
`define DSS_START_TIME_MAX 16'h03e8
`define DSS_STOP_TIME_MAX 16'h0168
`define DSS_PCT_MAX 7'h64
`define DSS_PCT_RST 7'h32
`define DSS_RATIO_FULL 10'h3e8
`define DSS_RATIO_RST 10'h12c
`endif

/* design/dss_pkg.sv */
package dss_pkg;
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_START_BRAKE, ST_MAGNETISE, ST_TRACK, ST_HOLD,
		ST_RUN, ST_STOP_RAMP, ST_STOP_DELAY, ST_STOP_BRAKE
	} dss_state_t;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dss_bus_t;
	// Set-points to the power stage
	typedef struct packed {
		logic run_en;
		logic dir;
		logic dc_en;
		logic cur_ref_motor;
		logic [6:0] cur_pct;
		logic [15:0] freq;
	} dss_stage_t;
endpackage

/* design/dss_sequencer.sv */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "dss_params.svh"
// How it works
// - Direct start, zero brake time: hold start
// - Direct start, nonzero time: DC brake first
// - Mode 1 tracks motor speed and direction together
// - Mode 2 magnetises asynchronous motors only
// - Zero pre-excitation time skips magnetising
// - Magnetise with set current for set time
// - Start frequency 0 to 10.00Hz, reset 0
// - Start hold up to 100.0s, reset 0
// - Start frequency ignores lower frequency limit
// - Target below start frequency stays standby
// - Direction changeover skips start hold
// - Hold excluded from ramp, counted runtime
// - Start brake direct only, 0-100%, 50%
// - Ramp mode 0 is linear
// - Ramp mode 1 is static S-curve
// - Ramp mode 2 is dynamic S-curve
// - S ratios 30% each, sum within 100%
// - Stop mode 0 ramps to zero
// - Stop mode 1 cuts output, coasts
// - At or below entry frequency, output off for delay
// - Stop brake current 0-100% motor, 50%
// - Stop brake hold to 36.0s, zero cancels
module dss_sequencer #(
	parameter int TICK_CYCLES = `DSS_TICK_NS / `DSS_CLK_NS
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst, // Synchronous reset, high
	input wire dss_pkg::dss_bus_t i_bus, // Register request
	input wire logic i_track_valid, // Speed estimate ready
	input wire logic [15:0] i_track_freq, // Estimated motor frequency
	input wire logic i_track_dir, // Estimated motor direction
	output dss_pkg::dss_stage_t o_stage, // Power stage set-points
	output logic [31:0] o_rdata // Read data, cycle after read
);
	import dss_pkg::*;

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] m);
		return (v > m) ? m : v;
	endfunction

	function automatic logic [6:0] clamp_pct(input logic [31:0] v);
		return (v > 32'(`DSS_PCT_MAX)) ? `DSS_PCT_MAX : v[6:0];
	endfunction

	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	// Shapes one ramp step from distance into an S zone
	function automatic logic [15:0] shape_step(input logic [15:0] base,
			input logic [15:0] d, input logic [15:0] zone, input logic deep);
		logic [15:0] s;
		s = base;
		if (d < zone) begin
			s = (deep && d < (zone >> 1)) ? base >> 2 : base >> 1;
		end
		return (s == 16'h0000 && base != 16'h0000) ? 16'h0001 : s;
	endfunction

	// Settings
	logic run_q, cdir_q, async_q;
	logic [1:0] start_mth_q, shape_q;
	logic stop_mth_q;
	logic [15:0] start_freq_q, hold_q, start_time_q, target_q, acc_q, dec_q;
	logic [15:0] stop_freq_q, stop_delay_q, stop_hold_q;
	logic [6:0] start_cur_q, stop_cur_q;
	logic [9:0] head_q, tail_q;
	// Sequencer state
	dss_state_t state_q, state_d;
	logic [15:0] f_q, f_d, org_q, goal_q, tm_q;
	logic dir_q, dir_d;
	logic [22:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] rt_q;

	// Write decode
	wire [31:0] wd = i_bus.wdata;
	wire wr_ctrl = i_bus.wr && i_bus.addr == `DSS_A_CTRL;
	wire wr_smth = i_bus.wr && i_bus.addr == `DSS_A_START_MTH;
	wire wr_sfreq = i_bus.wr && i_bus.addr == `DSS_A_START_FREQ;
	wire wr_shold = i_bus.wr && i_bus.addr == `DSS_A_START_HOLD;
	wire wr_scur = i_bus.wr && i_bus.addr == `DSS_A_START_CUR;
	wire wr_stime = i_bus.wr && i_bus.addr == `DSS_A_START_TIME;
	wire wr_shape = i_bus.wr && i_bus.addr == `DSS_A_RAMP_SHAPE;
	wire wr_head = i_bus.wr && i_bus.addr == `DSS_A_S_HEAD;
	wire wr_tail = i_bus.wr && i_bus.addr == `DSS_A_S_TAIL;
	wire wr_pmth = i_bus.wr && i_bus.addr == `DSS_A_STOP_MTH;
	wire wr_pfreq = i_bus.wr && i_bus.addr == `DSS_A_STOP_FREQ;
	wire wr_pdly = i_bus.wr && i_bus.addr == `DSS_A_STOP_DELAY;
	wire wr_pcur = i_bus.wr && i_bus.addr == `DSS_A_STOP_CUR;
	wire wr_phold = i_bus.wr && i_bus.addr == `DSS_A_STOP_HOLD;
	wire wr_tgt = i_bus.wr && i_bus.addr == `DSS_A_TARGET;
	wire wr_acc = i_bus.wr && i_bus.addr == `DSS_A_ACC_STEP;
	wire wr_dec = i_bus.wr && i_bus.addr == `DSS_A_DEC_STEP;
	// Each S ratio is bounded by what the other leaves
	wire [9:0] head_max = `DSS_RATIO_FULL - tail_q;
	wire [9:0] tail_max = `DSS_RATIO_FULL - head_q;
	wire [9:0] head_w = (wd > 32'(head_max)) ? head_max : wd[9:0];
	wire [9:0] tail_w = (wd > 32'(tail_max)) ? tail_max : wd[9:0];

	// Settings registers; ranged ones clamped on write, stop frequency, target and steps stored as written
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			{run_q, cdir_q, async_q} <= 3'h0;
			start_mth_q <= 2'h0;
			start_freq_q <= 16'h0000;
			hold_q <= 16'h0000;
			start_cur_q <= `DSS_PCT_RST;
			start_time_q <= 16'h0000;
			shape_q <= 2'h0;
			head_q <= `DSS_RATIO_RST;
			tail_q <= `DSS_RATIO_RST;
			stop_mth_q <= 1'b0;
			stop_freq_q <= 16'h0000;
			stop_delay_q <= 16'h0000;
			stop_cur_q <= `DSS_PCT_RST;
			stop_hold_q <= 16'h0000;
			target_q <= 16'h0000;
			acc_q <= 16'h0001;
			dec_q <= 16'h0001;
		end else begin
			if (wr_ctrl) begin
				run_q <= wd[`DSS_CTRL_RUN];
				cdir_q <= wd[`DSS_CTRL_DIR];
				async_q <= wd[`DSS_CTRL_ASYNC];
			end
			if (wr_smth) start_mth_q <= wd[1:0];
			if (wr_sfreq) start_freq_q <= clamp16(wd[15:0], `DSS_FREQ_MAX);
			if (wr_shold) hold_q <= clamp16(wd[15:0], `DSS_HOLD_MAX);
			if (wr_scur) start_cur_q <= clamp_pct(wd);
			if (wr_stime) start_time_q <= clamp16(wd[15:0], `DSS_START_TIME_MAX);
			if (wr_shape) shape_q <= (wd[1:0] == 2'h3) ? 2'h0 : wd[1:0];
			if (wr_head) head_q <= head_w;
			if (wr_tail) tail_q <= tail_w;
			if (wr_pmth) stop_mth_q <= wd[0];
			if (wr_pfreq) stop_freq_q <= wd[15:0];
			if (wr_pdly) stop_delay_q <= clamp16(wd[15:0], `DSS_STOP_TIME_MAX);
			if (wr_pcur) stop_cur_q <= clamp_pct(wd);
			if (wr_phold) stop_hold_q <= clamp16(wd[15:0], `DSS_STOP_TIME_MAX);
			if (wr_tgt) target_q <= wd[15:0];
			if (wr_acc) acc_q <= wd[15:0];
			if (wr_dec) dec_q <= wd[15:0];
		end
	end

	// Tick of 0.1s from the system clock
	wire tick_wrap = tick_cnt_q == 23'(TICK_CYCLES - 1);
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tick_cnt_q <= 23'h000000;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? 23'h000000 : tick_cnt_q + 23'h000001;
			tick_q <= tick_wrap;
		end
	end

	// Start conditions and timer ends
	wire go = run_q && target_q >= start_freq_q;
	wire tm_start = tm_q >= start_time_q;
	wire tm_hold = tm_q >= hold_q;
	wire tm_delay = tm_q >= stop_delay_q;
	wire tm_brake = tm_q >= stop_hold_q;
	wire dir_flip = cdir_q != dir_q;
	wire [15:0] goal = dir_flip ? 16'h0000 : target_q;

	// Ramp step, shaped near both ends of a ramp
	wire up = f_q < goal;
	wire [15:0] base = up ? acc_q : dec_q;
	wire [15:0] span = absdiff(goal, org_q);
	wire [25:0] zh_m = span * head_q;
	wire [25:0] zt_m = span * tail_q;
	wire [15:0] zone_h = zh_m[25:10];
	wire [15:0] zone_t = zt_m[25:10];
	wire [15:0] d_head = absdiff(f_q, org_q);
	wire [15:0] d_tail = absdiff(goal, f_q);
	wire in_head = d_head < zone_h;
	wire [15:0] s_d = in_head ? d_head : d_tail;
	wire [15:0] s_z = in_head ? zone_h : zone_t;
	wire [15:0] step = (shape_q == 2'h0) ? base :
		shape_step(base, s_d, s_z, shape_q == 2'h1);
	wire [15:0] f_ramp = (d_tail <= step) ? goal : (up ? f_q + step : f_q - step);
	// Decelerating stop toward zero is shaped near zero only, by the tail ratio
	wire [15:0] stop_span = org_q;
	wire [25:0] szt_m = stop_span * tail_q;
	wire [15:0] stop_step = (shape_q == 2'h0) ? dec_q :
		shape_step(dec_q, f_q, szt_m[25:10], shape_q == 2'h1);
	wire [15:0] f_stop = (f_q <= stop_step) ? 16'h0000 : f_q - stop_step;
	wire brake_entry = stop_hold_q != 16'h0000 && f_q <= stop_freq_q;

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		f_d = f_q;
		dir_d = dir_q;
		unique case (state_q)
			ST_IDLE: begin
				f_d = 16'h0000;
				if (go) begin
					dir_d = cdir_q;
					unique case (start_mth_q)
						2'h0: state_d = (start_time_q != 16'h0000) ? ST_START_BRAKE : ST_HOLD;
						2'h1: state_d = ST_TRACK;
						2'h2: state_d = (async_q && start_time_q != 16'h0000) ?
							ST_MAGNETISE : ST_HOLD;
						2'h3: state_d = ST_HOLD;
					endcase
				end
			end
			ST_START_BRAKE: begin
				if (!run_q) state_d = ST_IDLE;
				else if (tm_start) state_d = ST_HOLD;
			end
			ST_MAGNETISE: begin
				if (!run_q) state_d = ST_IDLE;
				else if (tm_start) state_d = ST_HOLD;
			end
			ST_TRACK: begin
				if (!run_q) state_d = ST_IDLE;
				else if (i_track_valid) begin
					f_d = i_track_freq;
					dir_d = i_track_dir;
					state_d = ST_RUN;
				end
			end
			ST_HOLD: begin
				f_d = start_freq_q;
				if (!run_q) state_d = stop_mth_q ? ST_IDLE : ST_STOP_RAMP;
				else if (tm_hold) state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!run_q) begin
					state_d = stop_mth_q ? ST_IDLE : ST_STOP_RAMP;
				end else if (dir_flip && f_q == 16'h0000) begin
					dir_d = cdir_q;
				end else begin
					f_d = f_ramp;
				end
			end
			ST_STOP_RAMP: begin
				if (brake_entry) begin
					f_d = 16'h0000;
					state_d = ST_STOP_DELAY;
				end else if (f_q == 16'h0000) begin
					state_d = ST_IDLE;
				end else begin
					f_d = f_stop;
				end
			end
			ST_STOP_DELAY: begin
				f_d = 16'h0000;
				if (tm_delay) state_d = ST_STOP_BRAKE;
			end
			ST_STOP_BRAKE: begin
				f_d = 16'h0000;
				if (tm_brake) state_d = ST_IDLE;
			end
		endcase
	end

	// Ramp origin follows each new goal or stop entry
	wire org_load = (goal != goal_q) || (state_d != state_q);

	// Sequencer registers and duration timer
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			f_q <= 16'h0000;
			dir_q <= 1'b0;
			org_q <= 16'h0000;
			goal_q <= 16'h0000;
			tm_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			f_q <= (state_q == ST_RUN || state_q == ST_STOP_RAMP) && !tick_q ? f_q : f_d;
			dir_q <= dir_d;
			goal_q <= goal;
			if (org_load) org_q <= f_q;
			if (state_d != state_q) tm_q <= 16'h0000;
			else if (tick_q && tm_q != 16'hffff) tm_q <= tm_q + 16'h0001;
		end
	end

	// Program runtime counts hold and run, not braking
	wire rt_clr = state_q == ST_IDLE && go;
	wire rt_inc = tick_q && (state_q == ST_HOLD || state_q == ST_RUN);
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) rt_q <= 32'h00000000;
		else if (rt_clr) rt_q <= 32'h00000000;
		else if (rt_inc) rt_q <= rt_q + 32'h00000001;
	end

	// Power stage set-points
	wire dc_start = state_q == ST_START_BRAKE || state_q == ST_MAGNETISE;
	wire dc_stop = state_q == ST_STOP_BRAKE;
	wire drive_on = state_q == ST_HOLD || state_q == ST_RUN || state_q == ST_STOP_RAMP;
	dss_stage_t stage_d;
	assign stage_d.run_en = drive_on;
	assign stage_d.dir = dir_q;
	assign stage_d.dc_en = dc_start || dc_stop;
	assign stage_d.cur_ref_motor = dc_stop;
	assign stage_d.cur_pct = dc_stop ? stop_cur_q : (dc_start ? start_cur_q : 7'h00);
	assign stage_d.freq = (state_q == ST_HOLD) ? start_freq_q : (drive_on ? f_q : 16'h0000);

	// Read mux
	wire [31:0] status_w = {8'h00, f_q, dir_q, 3'h0, state_q};
	logic [31:0] rd_w;
	always_comb begin
		unique case (i_bus.addr)
			`DSS_A_CTRL: rd_w = {29'h0, async_q, cdir_q, run_q};
			`DSS_A_START_MTH: rd_w = {30'h0, start_mth_q};
			`DSS_A_START_FREQ: rd_w = {16'h0, start_freq_q};
			`DSS_A_START_HOLD: rd_w = {16'h0, hold_q};
			`DSS_A_START_CUR: rd_w = {25'h0, start_cur_q};
			`DSS_A_START_TIME: rd_w = {16'h0, start_time_q};
			`DSS_A_RAMP_SHAPE: rd_w = {30'h0, shape_q};
			`DSS_A_S_HEAD: rd_w = {22'h0, head_q};
			`DSS_A_S_TAIL: rd_w = {22'h0, tail_q};
			`DSS_A_STOP_MTH: rd_w = {31'h0, stop_mth_q};
			`DSS_A_STOP_FREQ: rd_w = {16'h0, stop_freq_q};
			`DSS_A_STOP_DELAY: rd_w = {16'h0, stop_delay_q};
			`DSS_A_STOP_CUR: rd_w = {25'h0, stop_cur_q};
			`DSS_A_STOP_HOLD: rd_w = {16'h0, stop_hold_q};
			`DSS_A_TARGET: rd_w = {16'h0, target_q};
			`DSS_A_ACC_STEP: rd_w = {16'h0, acc_q};
			`DSS_A_DEC_STEP: rd_w = {16'h0, dec_q};
			`DSS_A_STATUS: rd_w = status_w;
			`DSS_A_RUNTIME: rd_w = rt_q;
			default: rd_w = 32'h00000000;
		endcase
	end

	// Output flops
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_stage <= '0;
			o_rdata <= 32'h00000000;
		end else begin
			o_stage <= stage_d;
			o_rdata <= i_bus.rd ? rd_w : 32'h00000000;
		end
	end

	// Checks
	a_direct_no_brake: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && go && start_mth_q == 2'h0 && start_time_q == 16'h0000
		|=> state_q == ST_HOLD ##1 o_stage.run_en && o_stage.freq == start_freq_q)
		else $error("direct start did not hold at start frequency");
	a_direct_brake_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && go && start_mth_q == 2'h0 && start_time_q != 16'h0000
		|=> state_q == ST_START_BRAKE ##1 o_stage.dc_en && !o_stage.run_en)
		else $error("direct start skipped DC braking");
	a_track_entry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_TRACK && run_q && i_track_valid
		|=> state_q == ST_RUN && f_q == $past(i_track_freq) && dir_q == $past(i_track_dir))
		else $error("tracking start lost motor speed");
	a_magnet_async: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		$rose(state_q == ST_MAGNETISE) |-> async_q && start_mth_q == 2'h2)
		else $error("magnetising without asynchronous motor");
	a_magnet_skip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && go && start_mth_q == 2'h2 && start_time_q == 16'h0000
		|=> state_q == ST_HOLD)
		else $error("zero pre-excitation time did not skip");
	a_magnet_current: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_MAGNETISE |=> o_stage.dc_en && o_stage.cur_pct == $past(start_cur_q))
		else $error("pre-excitation current wrong");
	a_start_ranges: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		start_freq_q <= `DSS_FREQ_MAX && hold_q <= `DSS_HOLD_MAX)
		else $error("start setting out of range");
	a_low_target_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && target_q < start_freq_q |=> state_q == ST_IDLE)
		else $error("started below start frequency");
	a_reverse_no_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_RUN && run_q && dir_flip && f_q == 16'h0000
		|=> state_q == ST_RUN && dir_q == $past(cdir_q))
		else $error("changeover left run state");
	a_hold_runtime: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rt_inc && !rt_clr |=> rt_q == $past(rt_q) + 32'h00000001)
		else $error("hold or run time not counted");
	a_linear_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		shape_q == 2'h0 |-> step == base)
		else $error("linear ramp step shaped");
	a_s_soft_ends: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		shape_q == 2'h1 && s_d < s_z && base > 16'h0003 |-> step <= (base >> 1))
		else $error("S-curve end not softened");
	a_s_ratio_sum: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		10'(head_q + tail_q) <= `DSS_RATIO_FULL && head_q + tail_q <= 11'h3e8)
		else $error("S ratios exceed full");
	a_coast_cut: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_RUN && !run_q && stop_mth_q |=> state_q == ST_IDLE ##1 !o_stage.run_en)
		else $error("coast stop kept output");
	a_delay_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_STOP_DELAY |=> !o_stage.run_en && !o_stage.dc_en)
		else $error("output during brake delay");
	a_zero_hold_cancel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_STOP_RAMP && stop_hold_q == 16'h0000 |=> state_q != ST_STOP_DELAY)
		else $error("stop braking not cancelled");
endmodule

/* tb/dss_motor_model.sv */
`timescale 1ns/1ns
// Inverter stage plus motor: follows the set-points, coasts when released
module dss_motor_model (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst, // Synchronous reset, high
	input wire dss_pkg::dss_stage_t i_stage, // Set-points from the sequencer
	input wire logic i_slow, // Slow speed estimator
	output logic o_valid, // Speed estimate ready
	output logic [15:0] o_freq, // Estimated motor frequency
	output logic o_dir // Estimated motor direction
);
	import dss_pkg::*;
	logic [15:0] speed_q;
	logic dir_q;
	logic [7:0] coast_q;
	// Shaft follows the drive while it runs, DC current stops it, else it coasts
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			speed_q <= 16'h0000;
			dir_q <= 1'b0;
			coast_q <= 8'h00;
		end else if (i_stage.run_en) begin
			speed_q <= i_stage.freq;
			dir_q <= i_stage.dir;
			coast_q <= 8'h00;
		end else begin
			if (i_stage.dc_en) speed_q <= 16'h0000;
			if (coast_q != 8'hff) coast_q <= coast_q + 8'h01;
		end
	end
	// Estimate settles some cycles after output stops; lines scrambled until then
	assign o_valid = !i_stage.run_en && (coast_q >= (i_slow ? 8'h32 : 8'h02));
	assign o_freq = o_valid ? speed_q : ~speed_q;
	assign o_dir = o_valid ? dir_q : ~dir_q;
endmodule

/* tb/dss_sequencer_tb.sv */
`timescale 1ns/1ns
`include "dss_params.svh"
module dss_sequencer_tb;
	import dss_pkg::*;
	logic clk;
	logic rst;
	logic slow;
	dss_bus_t bus;
	logic trk_valid;
	logic [15:0] trk_freq;
	logic trk_dir;
	dss_stage_t stage;
	logic [31:0] rdata;
	logic [31:0] v;
	int errors;
	int n_checks;

	dss_sequencer #(.TICK_CYCLES(20)) uut (
		.i_clk_sys(clk),
		.i_rst(rst),
		.i_bus(bus),
		.i_track_valid(trk_valid),
		.i_track_freq(trk_freq),
		.i_track_dir(trk_dir),
		.o_stage(stage),
		.o_rdata(rdata)
	);

	dss_motor_model motor (
		.i_clk_sys(clk),
		.i_rst(rst),
		.i_stage(stage),
		.i_slow(slow),
		.o_valid(trk_valid),
		.o_freq(trk_freq),
		.o_dir(trk_dir)
	);

	// 50 MHz system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Verdict and end of run
	task stop_test;
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Compare seen against expected, count and report
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask

	// Bus write: one strobe cycle, then a quiet cycle
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	// Bus read: data stands in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [31:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk("register", d, exp);
	endtask

	// Poll the state field under a bounded count
	task wait_state(input dss_state_t st);
		logic [31:0] s;
		bit ok;
		ok = 0;
		s = '0;
		for (int i = 0; i < 300 && !ok; i++) begin
			rd(`DSS_A_STATUS, s);
			ok = (s[3:0] === st);
		end
		if (!ok) begin
			$display("ERROR state wait expected %h seen %h", st, s[3:0]);
			errors++;
			stop_test();
		end
	endtask

	// Stage set-points apart from direction, sampled mid-cycle
	task chk_st(input logic r, input logic dc, input logic m, input logic [6:0] c,
			input logic [15:0] f);
		@(negedge clk);
		chk("o_stage", {6'h00, stage.run_en, stage.dc_en, stage.cur_ref_motor,
			stage.cur_pct, stage.freq}, {6'h00, r, dc, m, c, f});
		@(posedge clk);
	endtask

	// Reset values, clamping, ramp shapes and an unmapped place
	task t_regs;
		rd_chk(`DSS_A_START_FREQ, 32'h0);
		rd_chk(`DSS_A_START_HOLD, 32'h0);
		rd_chk(`DSS_A_START_CUR, 32'h32);
		rd_chk(`DSS_A_STOP_CUR, 32'h32);
		rd_chk(`DSS_A_S_HEAD, 32'h12c);
		rd_chk(`DSS_A_S_TAIL, 32'h12c);
		wr(`DSS_A_START_FREQ, 32'h7d0);
		rd_chk(`DSS_A_START_FREQ, 32'h3e8);
		wr(`DSS_A_START_HOLD, 32'h1388);
		rd_chk(`DSS_A_START_HOLD, 32'h3e8);
		wr(`DSS_A_STOP_HOLD, 32'h3e8);
		rd_chk(`DSS_A_STOP_HOLD, 32'h168);
		wr(`DSS_A_STOP_DELAY, 32'h3e7);
		rd_chk(`DSS_A_STOP_DELAY, 32'h168);
		wr(`DSS_A_S_HEAD, 32'h320);
		rd_chk(`DSS_A_S_HEAD, 32'h2bc);
		wr(`DSS_A_START_CUR, 32'h78);
		rd_chk(`DSS_A_START_CUR, 32'h64);
		for (int m = 0; m < 4; m++) begin
			wr(`DSS_A_RAMP_SHAPE, m);
			rd_chk(`DSS_A_RAMP_SHAPE, (m == 3) ? 0 : m);
		end
		wr(8'hfc, 32'h5a5a);
		rd_chk(8'hfc, 32'h0);
	endtask

	// Target below start frequency: no start
	task t_standby;
		wr(`DSS_A_START_FREQ, 32'h64);
		wr(`DSS_A_START_HOLD, 32'h2);
		wr(`DSS_A_START_TIME, 32'h0);
		wr(`DSS_A_S_HEAD, 32'h12c);
		wr(`DSS_A_RAMP_SHAPE, 32'h0);
		wr(`DSS_A_ACC_STEP, 32'h32);
		wr(`DSS_A_DEC_STEP, 32'h32);
		wr(`DSS_A_TARGET, 32'h63);
		wr(`DSS_A_CTRL, 32'h1);
		repeat (60) @(posedge clk);
		rd(`DSS_A_STATUS, v);
		chk("state", v[3:0], ST_IDLE);
		chk_st(0, 0, 0, 7'h00, 16'h0000);
		wr(`DSS_A_CTRL, 32'h0);
	endtask

	// Direct start without braking, linear ramp, coast stop
	task t_direct_nobrake;
		wr(`DSS_A_TARGET, 32'h12c);
		wr(`DSS_A_STOP_MTH, 32'h1);
		wr(`DSS_A_CTRL, 32'h3);
		@(posedge clk);
		rd(`DSS_A_STATUS, v);
		chk("state", v[3:0], ST_HOLD);
		chk_st(1, 0, 0, 7'h00, 16'h0064);
		wait_state(ST_RUN);
		repeat (120) @(posedge clk);
		chk_st(1, 0, 0, 7'h00, 16'h012c);
		wr(`DSS_A_CTRL, 32'h2);
		@(posedge clk);
		chk_st(0, 0, 0, 7'h00, 16'h0000);
		rd(`DSS_A_STATUS, v);
		chk("state", v[3:0], ST_IDLE);
	endtask

	// Flying restart on the coasting motor, estimator slow
	task t_track;
		slow <= 1'b1;
		wr(`DSS_A_START_MTH, 32'h1);
		wr(`DSS_A_CTRL, 32'h3);
		wait_state(ST_RUN);
		chk_st(1, 0, 0, 7'h00, 16'h012c);
		@(negedge clk);
		chk("dir", stage.dir, 1'b1);
		@(posedge clk);
		wr(`DSS_A_CTRL, 32'h2);
		slow <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Braked start, then decelerating stop with delayed DC braking
	task t_brake_stop;
		wr(`DSS_A_START_MTH, 32'h0);
		wr(`DSS_A_START_TIME, 32'h2);
		wr(`DSS_A_START_CUR, 32'h28);
		wr(`DSS_A_STOP_MTH, 32'h0);
		wr(`DSS_A_STOP_FREQ, 32'hc8);
		wr(`DSS_A_STOP_DELAY, 32'h1);
		wr(`DSS_A_STOP_CUR, 32'h46);
		wr(`DSS_A_STOP_HOLD, 32'h2);
		wr(`DSS_A_CTRL, 32'h1);
		wait_state(ST_START_BRAKE);
		chk_st(0, 1, 0, 7'h28, 16'h0000);
		wait_state(ST_HOLD);
		chk_st(1, 0, 0, 7'h00, 16'h0064);
		wait_state(ST_RUN);
		repeat (120) @(posedge clk);
		chk_st(1, 0, 0, 7'h00, 16'h012c);
		wr(`DSS_A_CTRL, 32'h0);
		wait_state(ST_STOP_RAMP);
		wait_state(ST_STOP_DELAY);
		chk_st(0, 0, 0, 7'h00, 16'h0000);
		wait_state(ST_STOP_BRAKE);
		chk_st(0, 1, 1, 7'h46, 16'h0000);
		wait_state(ST_IDLE);
		chk_st(0, 0, 0, 7'h00, 16'h0000);
	endtask

	// Pre-excitation with and without a magnetising time
	task t_preexcite;
		wr(`DSS_A_START_MTH, 32'h2);
		wr(`DSS_A_START_CUR, 32'h1e);
		wr(`DSS_A_STOP_MTH, 32'h1);
		wr(`DSS_A_CTRL, 32'h5);
		wait_state(ST_MAGNETISE);
		chk_st(0, 1, 0, 7'h1e, 16'h0000);
		wait_state(ST_HOLD);
		chk_st(1, 0, 0, 7'h00, 16'h0064);
		wr(`DSS_A_CTRL, 32'h4);
		repeat (3) @(posedge clk);
		wr(`DSS_A_START_TIME, 32'h0);
		wr(`DSS_A_CTRL, 32'h5);
		@(posedge clk);
		rd(`DSS_A_STATUS, v);
		chk("state", v[3:0], ST_HOLD);
		wr(`DSS_A_CTRL, 32'h4);
	endtask

	// Runtime after hold, then direction changeover on an S-curve with no hold
	task t_reverse;
		logic [15:0] lo;
		lo = 16'h0000;
		wr(`DSS_A_START_MTH, 32'h0);
		wr(`DSS_A_CTRL, 32'h1);
		wait_state(ST_RUN);
		rd_chk(`DSS_A_RUNTIME, 32'h2);
		repeat (120) @(posedge clk);
		wr(`DSS_A_RAMP_SHAPE, 32'h1);
		wr(`DSS_A_CTRL, 32'h3);
		for (int i = 0; i < 300; i++) begin
			rd(`DSS_A_STATUS, v);
			chk("state", v[3:0], ST_RUN);
			if (lo == 16'h0000 && !v[7] && v[23:8] != 16'h012c) lo = v[23:8];
		end
		chk("s head step", lo, 16'h0120);
		chk("status dir", v[7], 1'b1);
		chk("status freq", v[23:8], 16'h012c);
		@(negedge clk);
		chk("o_stage dir", stage.dir, 1'b1);
		@(posedge clk);
		wr(`DSS_A_CTRL, 32'h2);
	endtask

	// Main sequence
	initial begin
		errors = 0;
		n_checks = 0;
		rst = 1'b1;
		slow = 1'b0;
		bus = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_standby();
		t_direct_nobrake();
		t_track();
		t_brake_stop();
		t_preexcite();
		t_reverse();
		stop_test();
	end
endmodule
